/* design/icf_flags_top.sv */
// i2c bus condition flags with apb register access
//
// Functional notes
// RL1: start detection sets start-seen flag; it marks the address period.
// RL2: start-seen clears on stop, next byte first clock, exit, disable, reset.
// RL3: stop detection sets stop-seen flag; the bus is released.
// RL4: stop-seen clears at address first clock after start, disable, reset.
// RL5: flag register is byte and bit accessible; reset makes it zero.
// RL6: bits 7 and 6 read-only; bits 5 to 2 read zero.
// RL7: software writes bits 1 and 0 only while unit is disabled.
// RL8: failed start with reservation disabled sets failure, drops start request.
// RL9: failure flag clears on start request write or disable.
// RL10: busy flag clears on stop detection or disable.
// RL11: busy sets on start detection, or on enable with initial control 0.
// RL12: initial control 0 waits for stop; 1 allows start; start clears it.
// RL13: reservation disable bit: 0 enables, 1 disables reservation.
// RL14: with initial control 1 software checks bus idle before first start.
// RL15: ack flag sets on low data at ninth clock; clears like start-seen.
// RL16: start is data falling with clock high; stop is data rising.
`timescale 1ns/10ps
module icf_flags_top
(
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // apb slave
    input wire icf_pkg::icf_apb_req_t apbReq,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // i2c pin levels
    input wire logic serialClockPin,
    input wire logic serialDataPin,
    // start generation handshake
    output logic startGo,
    output logic startAllowed,
    // interrupt
    output logic irq
);
    import icf_pkg::*;

    logic sclS, sdaS;
    icf_flag_t flag_r, flag_nxt;
    logic enable_r, enable_nxt, startReq_r, startReq_nxt;
    logic startSeen_r, startSeen_nxt, stopSeen_r, stopSeen_nxt;
    logic ackSeen_r, ackSeen_nxt, addrByte_r, addrByte_nxt;
    logic sclPrev_r, sdaPrev_r, go_r, go_nxt;
    logic [3:0] bitCnt_r, bitCnt_nxt;
    icf_evt_t irqStat_r, irqStat_nxt, irqMask_r, irqMask_nxt;
    icf_evt_t rdClr_r, rdClr_nxt, evt;
    logic [31:0] rdata_r, rdata_nxt;
    logic sclRise, startEv, stopEv, firstClk, ninthClk, disableEv, enableEv;
    logic setupPh, accessPh, wrEn, rdEn, hitFlag, hitCtrl, hitStat;
    logic hitIrqs, hitIrqm, mapped, failEv, goEv, exitEv, startWr;

    // pin synchronisers
    icf_sync #(.RST_VAL(ICF_PIN_RST)) u_sync_scl
    (
        .clk(clk),
        .sys_rst(sys_rst),
        .din(serialClockPin),
        .dout(sclS)
    );
    icf_sync #(.RST_VAL(ICF_PIN_RST)) u_sync_sda
    (
        .clk(clk),
        .sys_rst(sys_rst),
        .din(serialDataPin),
        .dout(sdaS)
    );

    // bus conditions found from synchronised levels
    assign sclRise = enable_r & sclS & ~sclPrev_r;
    assign startEv = enable_r & sclS & sclPrev_r & sdaPrev_r & ~sdaS; // see RL16
    assign stopEv = enable_r & sclS & sclPrev_r & ~sdaPrev_r & sdaS; // see RL16
    assign firstClk = sclRise & (bitCnt_r == ICF_CNT_START
        | bitCnt_r == ICF_CNT_NINE);
    assign ninthClk = sclRise & (bitCnt_r == ICF_CNT_EIGHT);

    // apb decode
    assign setupPh = apbReq.psel & ~apbReq.penable;
    assign accessPh = apbReq.psel & apbReq.penable;
    assign hitFlag = apbReq.paddr == ICF_FLAG_ADDR;
    assign hitCtrl = apbReq.paddr == ICF_CTRL_ADDR;
    assign hitStat = apbReq.paddr == ICF_STAT_ADDR;
    assign hitIrqs = apbReq.paddr == ICF_IRQS_ADDR;
    assign hitIrqm = apbReq.paddr == ICF_IRQM_ADDR;
    assign mapped = hitFlag | hitCtrl | hitStat | hitIrqs | hitIrqm;
    assign wrEn = accessPh & apbReq.pwrite & apbReq.pstrb[0]; // see RL5
    assign rdEn = accessPh & ~apbReq.pwrite;
    assign pready = 1'b1;
    assign pslverr = accessPh & ~mapped;

    // software commands
    assign disableEv = wrEn & hitCtrl & enable_r
        & ~apbReq.pwdata[ICF_CTRL_ENABLE];
    assign enableEv = wrEn & hitCtrl & ~enable_r
        & apbReq.pwdata[ICF_CTRL_ENABLE];
    assign exitEv = wrEn & hitCtrl & enable_r
        & apbReq.pwdata[ICF_CTRL_EXIT];
    assign startWr = wrEn & hitCtrl & enable_r
        & apbReq.pwdata[ICF_CTRL_START];
    // pending start resolves: free bus goes, busy bus fails if not reserved
    assign goEv = startReq_r & enable_r & ~flag_r.busBusy;
    assign failEv = startReq_r & enable_r & flag_r.busBusy
        & flag_r.resvDisable; // see RL8

    // events that raise interrupt status
    always_comb
    begin
        evt.startDet = startEv;
        evt.stopDet = stopEv;
        evt.startFail = failEv;
        evt.ackDet = ninthClk & ~sdaS;
    end

    // next-state of flags, counters and registers
    always_comb
    begin
        flag_nxt = flag_r;
        enable_nxt = enable_r;
        startReq_nxt = startReq_r;
        startSeen_nxt = startSeen_r;
        stopSeen_nxt = stopSeen_r;
        ackSeen_nxt = ackSeen_r;
        addrByte_nxt = addrByte_r;
        bitCnt_nxt = bitCnt_r;
        irqMask_nxt = irqMask_r;
        go_nxt = 1'b0;
        rdClr_nxt = ICF_IRQ_RST;
        rdata_nxt = rdata_r;
        // software writes to control and configuration
        if (wrEn & hitCtrl)
            enable_nxt = apbReq.pwdata[ICF_CTRL_ENABLE];
        if (wrEn & hitIrqm)
            irqMask_nxt = apbReq.pwdata[3:0];
        if (wrEn & hitFlag & ~enable_r)
        begin
            flag_nxt.initStart = apbReq.pwdata[1]; // see RL7
            flag_nxt.resvDisable = apbReq.pwdata[0]; // see RL13
        end
        // bit counting on the serial clock
        if (sclRise & bitCnt_r != ICF_CNT_IDLE)
        begin
            if (bitCnt_r == ICF_CNT_NINE)
            begin
                bitCnt_nxt = 4'h1;
                addrByte_nxt = 1'b0;
            end
            else
                bitCnt_nxt = bitCnt_r + 4'h1;
        end
        // clears first, sets after so a set in the same cycle wins
        if (firstClk & bitCnt_r == ICF_CNT_NINE & addrByte_r)
            startSeen_nxt = 1'b0; // see RL2
        if (firstClk & bitCnt_r == ICF_CNT_START & stopSeen_r)
            stopSeen_nxt = 1'b0; // see RL4
        if (firstClk & bitCnt_r == ICF_CNT_NINE)
            ackSeen_nxt = 1'b0; // see RL15
        if (stopEv | exitEv)
        begin
            startSeen_nxt = 1'b0; // see RL2
            ackSeen_nxt = 1'b0; // see RL15
        end
        if (exitEv)
            bitCnt_nxt = ICF_CNT_IDLE;
        if (startWr)
            flag_nxt.startFail = 1'b0; // see RL9
        if (stopEv)
        begin
            stopSeen_nxt = 1'b1; // see RL3
            flag_nxt.busBusy = 1'b0; // see RL10
            bitCnt_nxt = ICF_CNT_IDLE;
        end
        if (startEv)
        begin
            startSeen_nxt = 1'b1; // see RL1
            flag_nxt.busBusy = 1'b1; // see RL11
            flag_nxt.initStart = 1'b0; // see RL12
            bitCnt_nxt = ICF_CNT_START;
            addrByte_nxt = 1'b1;
        end
        if (ninthClk & ~sdaS)
            ackSeen_nxt = 1'b1; // see RL15
        if (enableEv & ~flag_r.initStart)
            flag_nxt.busBusy = 1'b1; // see RL11
        // start request: resolved once, then handed on or failed
        if (goEv)
        begin
            startReq_nxt = 1'b0;
            go_nxt = 1'b1; // see RL12
        end
        if (failEv)
        begin
            startReq_nxt = 1'b0; // see RL8
            flag_nxt.startFail = 1'b1; // see RL8
        end
        if (startWr)
            startReq_nxt = 1'b1;
        // operation stop clears bus flags, failure, busy, request and bit count; bits 1 and 0 and irq state kept
        if (disableEv)
        begin
            startSeen_nxt = 1'b0; // see RL2
            stopSeen_nxt = 1'b0; // see RL4
            ackSeen_nxt = 1'b0; // see RL15
            flag_nxt.startFail = 1'b0; // see RL9
            flag_nxt.busBusy = 1'b0; // see RL10
            startReq_nxt = 1'b0;
            bitCnt_nxt = ICF_CNT_IDLE;
        end
        flag_nxt.zero = 4'h0; // see RL6
        // read data captured in setup, status bits marked for clear
        if (setupPh & ~apbReq.pwrite)
        begin
            rdata_nxt = ICF_RDATA_RST;
            if (hitFlag)
                rdata_nxt[7:0] = flag_r; // see RL6
            if (hitCtrl)
            begin
                rdata_nxt[ICF_CTRL_ENABLE] = enable_r;
                rdata_nxt[ICF_CTRL_START] = startReq_r;
            end
            if (hitStat)
            begin
                rdata_nxt[ICF_STAT_START] = startSeen_r;
                rdata_nxt[ICF_STAT_STOP] = stopSeen_r;
                rdata_nxt[ICF_STAT_ACK] = ackSeen_r;
                rdata_nxt[ICF_STAT_SCL] = sclS;
                rdata_nxt[ICF_STAT_SDA] = sdaS;
                rdata_nxt[ICF_STAT_ALLOW] = enable_r & ~flag_r.busBusy;
            end
            if (hitIrqs)
                rdata_nxt[3:0] = irqStat_r;
            if (hitIrqm)
                rdata_nxt[3:0] = irqMask_r;
        end
        if (setupPh & ~apbReq.pwrite & hitIrqs)
            rdClr_nxt = irqStat_r;
        // read clears only bits that were returned; new events win
        irqStat_nxt = irqStat_r;
        if (rdEn & hitIrqs)
            irqStat_nxt = irqStat_r & ~rdClr_r;
        irqStat_nxt = irqStat_nxt | evt;
    end

    // registers
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            flag_r <= ICF_FLAG_RST; // see RL5
            enable_r <= 1'b0;
            startReq_r <= 1'b0;
            startSeen_r <= 1'b0;
            stopSeen_r <= 1'b0;
            ackSeen_r <= 1'b0;
            addrByte_r <= 1'b0;
            bitCnt_r <= ICF_CNT_IDLE;
            sclPrev_r <= ICF_PIN_RST;
            sdaPrev_r <= ICF_PIN_RST;
            go_r <= 1'b0;
            irqStat_r <= ICF_IRQ_RST;
            irqMask_r <= ICF_IRQ_RST;
            rdClr_r <= ICF_IRQ_RST;
            rdata_r <= ICF_RDATA_RST;
        end
        else
        begin
            flag_r <= flag_nxt;
            enable_r <= enable_nxt;
            startReq_r <= startReq_nxt;
            startSeen_r <= startSeen_nxt;
            stopSeen_r <= stopSeen_nxt;
            ackSeen_r <= ackSeen_nxt;
            addrByte_r <= addrByte_nxt;
            bitCnt_r <= bitCnt_nxt;
            sclPrev_r <= sclS;
            sdaPrev_r <= sdaS;
            go_r <= go_nxt;
            irqStat_r <= irqStat_nxt;
            irqMask_r <= irqMask_nxt;
            rdClr_r <= rdClr_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // outputs
    assign prdata = rdata_r;
    assign startGo = go_r;
    assign startAllowed = enable_r & ~flag_r.busBusy; // see RL12
    assign irq = |(irqStat_r & irqMask_r);

    // assertions
    property p_start_sets; // see RL1
        @(posedge clk) disable iff (sys_rst) startEv & ~disableEv |=> startSeen_r;
    endproperty
    a_start_sets: assert property (p_start_sets)
        else $error("start seen not set after start");

    property p_stop_clears_start; // see RL2
        @(posedge clk) disable iff (sys_rst)
            stopEv & ~startEv & ~disableEv |=> ~startSeen_r && stopSeen_r;
    endproperty
    a_stop_clears_start: assert property (p_stop_clears_start)
        else $error("stop did not clear start seen");

    property p_stop_sets; // see RL3
        @(posedge clk) disable iff (sys_rst)
            stopEv & ~disableEv |=> stopSeen_r ##1 stopSeen_r | ~enable_r
            | $past(firstClk);
    endproperty
    a_stop_sets: assert property (p_stop_sets)
        else $error("stop seen not held");

    property p_disable_clears; // see RL4
        @(posedge clk) disable iff (sys_rst) disableEv |=>
            ~stopSeen_r && ~startSeen_r && ~ackSeen_r && ~flag_r.busBusy;
    endproperty
    a_disable_clears: assert property (p_disable_clears)
        else $error("disable left a flag set");

    property p_reset_zero; // see RL5
        @(posedge clk) sys_rst |=> flag_r == ICF_FLAG_RST && irq == 1'b0;
    endproperty
    a_reset_zero: assert property (p_reset_zero)
        else $error("flag register not zero after reset");

    property p_ro_bits; // see RL6
        @(posedge clk) disable iff (sys_rst) wrEn & hitFlag & ~failEv
            & ~startWr & ~startEv & ~stopEv & ~enableEv |=>
            flag_r.zero == 4'h0 && $stable(flag_r.startFail)
            && $stable(flag_r.busBusy);
    endproperty
    a_ro_bits: assert property (p_ro_bits)
        else $error("read-only flag bits changed by write");

    property p_fail_sets; // see RL8
        @(posedge clk) disable iff (sys_rst)
            failEv & ~disableEv & ~startWr |=> flag_r.startFail && ~startReq_r
            && ~startGo;
    endproperty
    a_fail_sets: assert property (p_fail_sets)
        else $error("start failure not flagged");

    property p_fail_clears; // see RL9
        @(posedge clk) disable iff (sys_rst)
            (startWr | disableEv) & ~failEv |=> ~flag_r.startFail;
    endproperty
    a_fail_clears: assert property (p_fail_clears)
        else $error("start failure not cleared");

    property p_busy_on_enable; // see RL11
        @(posedge clk) disable iff (sys_rst)
            enableEv & ~flag_r.initStart |=> flag_r.busBusy && ~startAllowed;
    endproperty
    a_busy_on_enable: assert property (p_busy_on_enable)
        else $error("bus not busy after enable");

    property p_init_clear; // see RL12
        @(posedge clk) disable iff (sys_rst) startEv |=> ~flag_r.initStart;
    endproperty
    a_init_clear: assert property (p_init_clear)
        else $error("initial start control not cleared by start");

    property p_ack_sets; // see RL15
        @(posedge clk) disable iff (sys_rst)
            ninthClk & ~sdaS & ~disableEv |=> ackSeen_r;
    endproperty
    a_ack_sets: assert property (p_ack_sets)
        else $error("ack not detected at ninth clock");

    c_start_stop: cover property (@(posedge clk) disable iff (sys_rst)
        startEv ##[1:1000] stopEv);
    c_fail: cover property (@(posedge clk) disable iff (sys_rst) failEv);
    c_go: cover property (@(posedge clk) disable iff (sys_rst) startGo);
    c_irq_read: cover property (@(posedge clk) disable iff (sys_rst)
        irq ##1 rdEn & hitIrqs);
endmodule

/* design/icf_pkg.sv */
// package: constants and types of the i2c bus condition flag block
package icf_pkg;
    // flag register index as printed; byte address is four times it
    localparam logic [27:0] ICF_FLAG_IDX = 28'hFFF_FD8A;
    localparam logic [31:0] ICF_FLAG_ADDR = {2'b00, ICF_FLAG_IDX, 2'b00};
    // further registers of this block
    localparam logic [31:0] ICF_CTRL_ADDR = 32'h3FFF_F640;
    localparam logic [31:0] ICF_STAT_ADDR = 32'h3FFF_F644;
    localparam logic [31:0] ICF_IRQS_ADDR = 32'h3FFF_F648;
    localparam logic [31:0] ICF_IRQM_ADDR = 32'h3FFF_F64C;
    // control register bit positions
    localparam int ICF_CTRL_ENABLE = 0;
    localparam int ICF_CTRL_START = 1;
    localparam int ICF_CTRL_EXIT = 2;
    // status register bit positions
    localparam int ICF_STAT_START = 0;
    localparam int ICF_STAT_STOP = 1;
    localparam int ICF_STAT_ACK = 2;
    localparam int ICF_STAT_SCL = 3;
    localparam int ICF_STAT_SDA = 4;
    localparam int ICF_STAT_ALLOW = 5;
    // bit counter: idle value, ninth clock, reload after a start
    localparam logic [3:0] ICF_CNT_IDLE = 4'hF;
    localparam logic [3:0] ICF_CNT_NINE = 4'h9;
    localparam logic [3:0] ICF_CNT_EIGHT = 4'h8;
    localparam logic [3:0] ICF_CNT_START = 4'h0;
    // synchroniser depth for pin inputs
    localparam int ICF_SYNC_STAGES = 2;
    // pin level after reset: released bus reads high
    localparam logic ICF_PIN_RST = 1'b1;
    // values after reset
    localparam logic [7:0] ICF_FLAG_RST = 8'h00;
    localparam logic [3:0] ICF_IRQ_RST = 4'h0;
    localparam logic [31:0] ICF_RDATA_RST = 32'h0000_0000;

    // flag register layout, bit 7 down to bit 0
    typedef struct packed {
        logic startFail;
        logic busBusy;
        logic [3:0] zero;
        logic initStart;
        logic resvDisable;
    } icf_flag_t;

    // interrupt events, one bit each, same layout in status and mask
    typedef struct packed {
        logic ackDet;
        logic startFail;
        logic stopDet;
        logic startDet;
    } icf_evt_t;

    // apb request as seen by the slave
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] paddr;
        logic [31:0] pwdata;
        logic [3:0] pstrb;
    } icf_apb_req_t;
endpackage

/* design/icf_sync.sv */
// two-flop synchroniser for one pin input
`timescale 1ns/10ps
module icf_sync
#(
    parameter logic RST_VAL = 1'b1
)
(
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // asynchronous level in, synchronised level out
    input wire logic din,
    output logic dout
);
    logic stage1_r;
    logic stage2_r;

    // first stage feeds only the second
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            stage1_r <= RST_VAL;
            stage2_r <= RST_VAL;
        end
        else
        begin
            stage1_r <= din;
            stage2_r <= stage1_r;
        end
    end

    assign dout = stage2_r;
endmodule

/* verification/icf_bus_model.sv */
// behavioural model of another master driving the two-wire bus
`timescale 1ns/10ps
module icf_bus_model
(
    // wired bus levels, pulled up when released
    output logic sclLine,
    output logic sdaLine
);
    // half period of the 400 ns link clock
    localparam int HALF_NS = 200;

    // both lines released: pull-ups hold them high
    initial
    begin
        sclLine = 1'b1;
        sdaLine = 1'b1;
    end

    // data falls while the clock stays high
    task automatic busStart();
        sclLine = 1'b1;
        #(HALF_NS);
        sdaLine = 1'b0;
        #(HALF_NS);
        sclLine = 1'b0;
        #(HALF_NS);
    endtask

    // one clock pulse; data is released again once the clock is low
    task automatic busBit(input logic b);
        sdaLine = b;
        #(HALF_NS);
        sclLine = 1'b1;
        #(HALF_NS);
        sclLine = 1'b0;
        #(HALF_NS / 4);
        sdaLine = 1'b1;
        #(HALF_NS);
    endtask

    // clock low first so the data drop is no start, then data rises
    task automatic busStop();
        sclLine = 1'b0;
        #(HALF_NS);
        sdaLine = 1'b0;
        #(HALF_NS);
        sclLine = 1'b1;
        #(HALF_NS);
        sdaLine = 1'b1;
        #(HALF_NS);
    endtask
endmodule

/* verification/tb_i2c_bus_condition_flags.sv */
// self-checking bench for the i2c bus condition flag block
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin nCompared++; if ((got) !== (exp)) \
    begin failures++; \
    $display("[FAIL] %s expected %h seen %h", nm, exp, got); end end
module tb_i2c_bus_condition_flags;
    import icf_pkg::*;
    logic clk;
    logic sys_rst;
    icf_apb_req_t apbReq;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic sclLine;
    logic sdaLine;
    logic startGo;
    logic startAllowed;
    logic irq;
    int failures = 0;
    int nCompared = 0;
    int goCount = 0;
    int goBefore;
    logic [31:0] rdVal;
    logic rdErr;

    // design and the other bus party
    icf_flags_top uut (.clk(clk), .sys_rst(sys_rst), .apbReq(apbReq),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .serialClockPin(sclLine), .serialDataPin(sdaLine),
        .startGo(startGo), .startAllowed(startAllowed), .irq(irq));
    icf_bus_model bus (.sclLine(sclLine), .sdaLine(sdaLine));

    // 20 mhz clock
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // count start hand-off pulses
    always @(posedge clk)
        if (startGo === 1'b1)
            goCount <= goCount + 1;

    // one apb transfer; read data taken at the completing edge
    task automatic apb(input logic wr, input logic [31:0] a,
        input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        apbReq.psel <= 1'b1;
        apbReq.penable <= 1'b0;
        apbReq.pwrite <= wr;
        apbReq.paddr <= a;
        apbReq.pwdata <= d;
        apbReq.pstrb <= wr ? 4'hF : 4'h0;
        @(posedge clk);
        apbReq.penable <= 1'b1;
        // wait for the rising edge at which pready is sampled high
        @(posedge clk);
        while (pready !== 1'b1 && n < 20)
        begin
            n++;
            @(posedge clk);
        end
        if (n == 20)
            `CHK("pready", 1'b1, pready)
        rdVal = prdata;
        rdErr = pslverr;
        apbReq.psel <= 1'b0;
        apbReq.penable <= 1'b0;
    endtask

    task automatic wr(input logic [31:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h00_0000, d});
    endtask

    // read and compare the masked low byte
    task automatic rdchk(input logic [31:0] a, input logic [7:0] m,
        input logic [7:0] e, input string nm);
        apb(1'b0, a, 32'h0000_0000);
        `CHK(nm, e, rdVal[7:0] & m)
    endtask

    // let pin changes pass the synchroniser and edge detect
    task automatic settle();
        repeat (3) @(posedge clk);
        @(negedge clk);
    endtask

    task automatic t_reset();
        rdchk(ICF_FLAG_ADDR, 8'hFF, 8'h00, "flag after reset");
        rdchk(ICF_STAT_ADDR, 8'h27, 8'h00, "status after reset");
        `CHK("irq after reset", 1'b0, irq)
    endtask

    task automatic t_flag_bits();
        wr(ICF_FLAG_ADDR, 8'hFF);
        rdchk(ICF_FLAG_ADDR, 8'hFF, 8'h03, "flag ro bits");
        wr(ICF_FLAG_ADDR, 8'h00);
        rdchk(ICF_FLAG_ADDR, 8'hFF, 8'h00, "flag cleared");
    endtask

    task automatic t_busy_stop();
        wr(ICF_CTRL_ADDR, 8'h01);
        rdchk(ICF_FLAG_ADDR, 8'hC0, 8'h40, "busy on enable");
        rdchk(ICF_STAT_ADDR, 8'h20, 8'h00, "start blocked");
        bus.busStop();
        settle();
        rdchk(ICF_STAT_ADDR, 8'h23, 8'h22, "stop seen");
        rdchk(ICF_FLAG_ADDR, 8'h40, 8'h00, "busy after stop");
    endtask

    task automatic t_transfer();
        bus.busStart();
        settle();
        rdchk(ICF_STAT_ADDR, 8'h03, 8'h03, "start seen");
        rdchk(ICF_FLAG_ADDR, 8'h40, 8'h40, "busy on start");
        bus.busBit(1'b1);
        settle();
        rdchk(ICF_STAT_ADDR, 8'h03, 8'h01, "first clock");
        repeat (7) bus.busBit(1'b1);
        bus.busBit(1'b0);
        settle();
        rdchk(ICF_STAT_ADDR, 8'h05, 8'h05, "ack at ninth");
        bus.busBit(1'b1);
        settle();
        rdchk(ICF_STAT_ADDR, 8'h05, 8'h00, "next byte");
        bus.busStart();
        bus.busBit(1'b1);
        bus.busStop();
        settle();
        rdchk(ICF_STAT_ADDR, 8'h03, 8'h02, "stop in address");
    endtask

    task automatic t_fail();
        wr(ICF_CTRL_ADDR, 8'h00);
        wr(ICF_FLAG_ADDR, 8'h01);
        wr(ICF_CTRL_ADDR, 8'h01);
        wr(ICF_CTRL_ADDR, 8'h03);
        rdchk(ICF_FLAG_ADDR, 8'hC1, 8'hC1, "start fail");
        rdchk(ICF_CTRL_ADDR, 8'h02, 8'h00, "request dropped");
        bus.busStop();
        settle();
        goBefore = goCount;
        wr(ICF_CTRL_ADDR, 8'h03);
        settle();
        rdchk(ICF_FLAG_ADDR, 8'h80, 8'h00, "fail on request");
        `CHK("start handed", goBefore + 1, goCount)
        bus.busStart();
        settle();
        wr(ICF_CTRL_ADDR, 8'h03);
        wr(ICF_CTRL_ADDR, 8'h00);
        rdchk(ICF_FLAG_ADDR, 8'hC1, 8'h01, "disable clears");
        rdchk(ICF_STAT_ADDR, 8'h03, 8'h00, "disable flags");
    endtask

    task automatic t_init_exit();
        bus.busStop();
        wr(ICF_FLAG_ADDR, 8'h02);
        wr(ICF_CTRL_ADDR, 8'h01);
        rdchk(ICF_FLAG_ADDR, 8'hC3, 8'h02, "released at on");
        rdchk(ICF_STAT_ADDR, 8'h20, 8'h20, "start allowed");
        bus.busStart();
        settle();
        rdchk(ICF_FLAG_ADDR, 8'hC3, 8'h40, "init cleared");
        wr(ICF_CTRL_ADDR, 8'h03);
        rdchk(ICF_CTRL_ADDR, 8'h02, 8'h02, "request kept");
        rdchk(ICF_FLAG_ADDR, 8'h80, 8'h00, "no fail");
        wr(ICF_CTRL_ADDR, 8'h05);
        rdchk(ICF_STAT_ADDR, 8'h01, 8'h00, "exit clears");
        goBefore = goCount;
        bus.busStop();
        settle();
        `CHK("reserved start", goBefore + 1, goCount)
        wr(ICF_CTRL_ADDR, 8'h00);
        rdchk(ICF_FLAG_ADDR, 8'h40, 8'h00, "busy off");
    endtask

    task automatic t_irq();
        wr(ICF_FLAG_ADDR, 8'h00);
        wr(ICF_IRQM_ADDR, 8'h00);
        apb(1'b0, ICF_IRQS_ADDR, 32'h0000_0000);
        wr(ICF_CTRL_ADDR, 8'h01);
        bus.busStop();
        settle();
        `CHK("irq masked", 1'b0, irq)
        wr(ICF_IRQM_ADDR, 8'h02);
        @(negedge clk);
        `CHK("irq raised", 1'b1, irq)
        rdchk(ICF_IRQS_ADDR, 8'h0F, 8'h02, "stop event");
        @(negedge clk);
        `CHK("irq cleared", 1'b0, irq)
        wr(ICF_CTRL_ADDR, 8'h00);
        apb(1'b0, 32'h0000_0010, 32'h0000_0000);
        `CHK("unmapped err", 1'b1, rdErr)
        `CHK("unmapped data", 32'h0000_0000, rdVal)
    endtask

    // verdict and end of run
    task automatic report_and_stop();
        $display("compared %0d failures %0d", nCompared, failures);
        if (failures == 0 && nCompared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // cut a hang short
    initial
    begin
        #2_000_000;
        failures++;
        report_and_stop();
    end

    // reset then scenarios in order
    initial
    begin
        sys_rst = 1'b1;
        apbReq = '0;
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        t_reset();
        t_flag_bits();
        t_busy_stop();
        t_transfer();
        t_fail();
        t_init_exit();
        t_irq();
        report_and_stop();
    end
endmodule
